// ### rtl/lbc_pkg.sv
package lbc_pkg;

    // ----------------------------------------
    // address map and reset values
    // ----------------------------------------
    localparam logic [19:0] UPPER_RST_LO = 20'h0_FFC00;
    localparam logic [19:0] UPPER_RST_HI = 20'h0_FFFFF;
    localparam logic [19:0] LOWER_RST_LO = 20'h0_0000;
    localparam logic [19:0] LOWER_RST_HI = 20'h0_0000;
    localparam logic [7:0] COPROC_ERR_VECTOR = 8'h10;
    localparam int CLOCK_MHZ = 40;

    // ----------------------------------------
    // carriers
    // ----------------------------------------
    typedef struct packed {
        logic [19:0] addr;
        logic is_write;
        logic is_io;
        logic is_coproc;
        logic locked;
        logic last_of_instr;
    } lbc_req_s;

    typedef struct packed {
        logic [19:0] lo;
        logic [19:0] hi;
        logic en_mem;
        logic en_io;
        logic ignore_ready;
    } lbc_region_s;

    typedef struct packed {
        logic read_n;
        logic write_n;
        logic data_transceiver_enable_n;
        logic transceiver_direction;
        logic lock_n;
    } lbc_ctl_s;

endpackage

// ### rtl/lbc_sync.sv
module lbc_sync
    import lbc_pkg::*;
#(
    parameter int W = 1
)(
    input wire logic clock,
    input wire logic rstn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] meta;

    // ----------------------------------------
    // two-stage synchroniser
    // ----------------------------------------
    // first stage feeds only the second
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            meta <= '0;
            q <= '0;
        end
        else
        begin
            meta <= d;
            q <= meta;
        end
    end

endmodule

// ### rtl/lbc_region.sv
module lbc_region
    import lbc_pkg::*;
(
    input wire lbc_region_s cfg,
    input wire logic [19:0] addr,
    input wire logic is_io,
    output logic hit
);

    // ----------------------------------------
    // range decode
    // ----------------------------------------
    // inclusive bounds; a disabled space never hits
    always_comb
    begin
        hit = (addr >= cfg.lo) && (addr <= cfg.hi) && (is_io ? cfg.en_io : cfg.en_mem);
    end

endmodule

// ### rtl/lbc_top.sv
// Function
// - read strobe asserted during read cycles so the target drives data
// - write strobe asserted during write cycles so target captures data
// - cycle extended until ready, unless region configured to ignore ready
// - transceiver enable active only while data is transferred
// - direction output: transmit for writes, receive for reads
// - while lock active, no bus grant to hold or others
// - hold honoured only at unlocked instruction boundary
// - float data and control outputs when hold acknowledge asserts
// - coprocessor select asserted for coprocessor accesses
// - error sampled active at numerics start raises interrupt type 16
// - upper select active for cycles inside its programmed range
// - upper select reset range covers memory 0FFC00H to 0FFFFFH
// - lower select active in range, inactive after reset until programmed
module lbc_top
    import lbc_pkg::*;
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic req_valid,
    input wire lbc_req_s req,
    output logic req_ready,
    output logic done,
    input wire logic cfg_we,
    input wire logic cfg_sel_lower,
    input wire lbc_region_s cfg_data,
    input wire logic ready_pin,
    input wire logic hold,
    input wire logic coproc_error_n,
    input wire logic coproc_transfer_request,
    input wire logic lock_in,
    output lbc_ctl_s ctl,
    output logic ctl_oe,
    output logic data_oe,
    output logic bus_grant_ack,
    output logic coproc_select_n,
    output logic upper_region_select_n,
    output logic lower_region_select_n,
    output logic coproc_irq,
    output logic [7:0] coproc_irq_vector,
    output logic coproc_xfer_pending,
    output logic lock_in_seen
);

    typedef enum logic [2:0] {IDLE, ADDR, DATA, WAIT, DONE, HELD} lbc_state_e;

    lbc_state_e state;
    lbc_req_s cur;
    lbc_region_s upper_cfg;
    lbc_region_s lower_cfg;
    logic ready_s;
    logic hold_s;
    logic error_n_s;
    logic xfer_s;
    logic lock_s;
    logic upper_hit;
    logic lower_hit;
    logic ignore_rdy;
    logic bus_locked;
    logic boundary;
    logic take;

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    lbc_sync #(.W(5)) u_sync (
        .clock(clock),
        .rstn(rstn),
        .d({ready_pin, hold, coproc_error_n, coproc_transfer_request, lock_in}),
        .q({ready_s, hold_s, error_n_s, xfer_s, lock_s})
    );

    // ----------------------------------------
    // region decoders
    // ----------------------------------------
    lbc_region u_upper (
        .cfg(upper_cfg),
        .addr(cur.addr),
        .is_io(cur.is_io),
        .hit(upper_hit)
    );

    lbc_region u_lower (
        .cfg(lower_cfg),
        .addr(cur.addr),
        .is_io(cur.is_io),
        .hit(lower_hit)
    );

    // region chosen ignores ready only if it actually decodes this cycle
    assign ignore_rdy = (upper_hit && upper_cfg.ignore_ready) || (lower_hit && lower_cfg.ignore_ready);
    assign bus_locked = (state != IDLE) && (state != HELD) && cur.locked;
    // a lock covers one instruction, so its last cycle also closes the locked run
    assign boundary = cur.last_of_instr;
    // a request is taken in idle unless the bus is handed over at this edge
    assign take = (state == IDLE) && req_valid && !(hold_s && boundary);

    // ----------------------------------------
    // region configuration
    // ----------------------------------------
    // upper reset range
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            upper_cfg <= '{lo: UPPER_RST_LO, hi: UPPER_RST_HI, en_mem: 1'b1, en_io: 1'b0, ignore_ready: 1'b0};
            lower_cfg <= '{lo: LOWER_RST_LO, hi: LOWER_RST_HI, en_mem: 1'b0, en_io: 1'b0, ignore_ready: 1'b0};
        end
        else if (cfg_we && state == IDLE)
        begin
            if (cfg_sel_lower)
                lower_cfg <= cfg_data;
            else
                upper_cfg <= cfg_data;
        end
    end

    // ----------------------------------------
    // bus cycle sequencer
    // ----------------------------------------
    // hold is only checked in idle after a boundary, so a locked run is never split
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            state <= IDLE;
            // after reset the core sits at an instruction boundary, so hold may be granted
            cur <= '{addr: 20'h0_0000, is_write: 1'b0, is_io: 1'b0, is_coproc: 1'b0, locked: 1'b0,
                     last_of_instr: 1'b1};
        end
        else
        begin
            unique case (state)
                IDLE:
                begin
                    if (hold_s && boundary)
                        state <= HELD;
                    else if (req_valid)
                    begin
                        cur <= req;
                        state <= ADDR;
                    end
                end
                ADDR: state <= DATA;
                DATA: state <= WAIT;
                WAIT:
                begin
                    if (ready_s || ignore_rdy)
                        state <= DONE;
                end
                DONE: state <= IDLE;
                HELD:
                begin
                    if (!hold_s)
                        state <= IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------
    // pin drivers
    // ----------------------------------------
    // all strobes registered so outputs are glitch free toward the pins
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            ctl <= '{read_n: 1'b1, write_n: 1'b1, data_transceiver_enable_n: 1'b1,
                     transceiver_direction: 1'b0, lock_n: 1'b1};
            ctl_oe <= 1'b0;
            data_oe <= 1'b0;
            bus_grant_ack <= 1'b0;
            coproc_select_n <= 1'b1;
            upper_region_select_n <= 1'b1;
            lower_region_select_n <= 1'b1;
            req_ready <= 1'b0;
            done <= 1'b0;
        end
        else
        begin
            ctl_oe <= (state != HELD) && !(state == IDLE && hold_s && boundary);
            bus_grant_ack <= (state == HELD) && hold_s;
            ctl.read_n <= !((state == DATA || state == WAIT) && !cur.is_write);
            ctl.write_n <= !((state == DATA || state == WAIT) && cur.is_write);
            ctl.data_transceiver_enable_n <= !(state == DATA || state == WAIT);
            ctl.transceiver_direction <= (state != IDLE && state != HELD) ? cur.is_write : 1'b0;
            ctl.lock_n <= !bus_locked;
            data_oe <= cur.is_write && (state == DATA || state == WAIT);
            coproc_select_n <= !(cur.is_coproc && state != IDLE && state != HELD && state != DONE);
            upper_region_select_n <= !(upper_hit && state != IDLE && state != HELD && state != DONE);
            lower_region_select_n <= !(lower_hit && state != IDLE && state != HELD && state != DONE);
            req_ready <= (state == IDLE) && !hold_s && !req_ready;
            done <= (state == WAIT) && (ready_s || ignore_rdy);
        end
    end

    // ----------------------------------------
    // coprocessor status
    // ----------------------------------------
    // error interrupt 16
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            coproc_irq <= 1'b0;
            coproc_irq_vector <= 8'h00;
            coproc_xfer_pending <= 1'b0;
            lock_in_seen <= 1'b0;
        end
        else
        begin
            coproc_irq <= take && req.is_coproc && !error_n_s;
            coproc_irq_vector <= COPROC_ERR_VECTOR;
            coproc_xfer_pending <= xfer_s;
            lock_in_seen <= !lock_s;
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    sequence s_hold_granted;
        bus_grant_ack;
    endsequence

    property p_rd_only_read;
        @(posedge clock) disable iff (!rstn) !ctl.read_n |-> !ctl.write_n == 1'b0;
    endproperty
    a_rd_only_read: assert property (p_rd_only_read) else $error("read and write both low");

    property p_wr_dir;
        @(posedge clock) disable iff (!rstn) !ctl.write_n |-> ctl.transceiver_direction;
    endproperty
    a_wr_dir: assert property (p_wr_dir) else $error("write without transmit direction");

    property p_no_done_without_ready;
        @(posedge clock) disable iff (!rstn) done |-> $past(ready_s) || $past(ignore_rdy);
    endproperty
    a_no_done_without_ready: assert property (p_no_done_without_ready) else $error("cycle ended without ready");

    property p_den_strobe;
        @(posedge clock) disable iff (!rstn) !ctl.data_transceiver_enable_n |-> (!ctl.read_n || !ctl.write_n);
    endproperty
    a_den_strobe: assert property (p_den_strobe) else $error("enable outside data phase");

    property p_lock_no_grant;
        @(posedge clock) disable iff (!rstn) !ctl.lock_n |-> !bus_grant_ack;
    endproperty
    a_lock_no_grant: assert property (p_lock_no_grant) else $error("grant while locked");

    property p_float_on_ack;
        @(posedge clock) disable iff (!rstn) s_hold_granted |-> !ctl_oe && !data_oe;
    endproperty
    a_float_on_ack: assert property (p_float_on_ack) else $error("driving bus while acknowledged");

    property p_ack_until_drop;
        @(posedge clock) disable iff (!rstn) bus_grant_ack && hold_s |=> bus_grant_ack;
    endproperty
    a_ack_until_drop: assert property (p_ack_until_drop) else $error("ack dropped while hold held");

    property p_err_irq;
        @(posedge clock) disable iff (!rstn)
            (state == IDLE) && req_valid && req.is_coproc && !error_n_s && !hold_s |=> coproc_irq;
    endproperty
    a_err_irq: assert property (p_err_irq) else $error("missing coprocessor error interrupt");

    sequence s_idle_mid_instr;
        (state == IDLE) && !boundary;
    endsequence

    property p_no_grant_mid_instr;
        @(posedge clock) disable iff (!rstn) s_idle_mid_instr |=> state != HELD;
    endproperty
    a_no_grant_mid_instr: assert property (p_no_grant_mid_instr) else $error("bus released mid instruction");

    property p_rd_dir;
        @(posedge clock) disable iff (!rstn) !ctl.read_n |-> !ctl.transceiver_direction;
    endproperty
    a_rd_dir: assert property (p_rd_dir) else $error("read without receive direction");

    property p_coproc_sel;
        @(posedge clock) disable iff (!rstn) (state == DATA) && cur.is_coproc |=> !coproc_select_n;
    endproperty
    a_coproc_sel: assert property (p_coproc_sel) else $error("coprocessor access without select");

    property p_upper_sel;
        @(posedge clock) disable iff (!rstn) (state == DATA) && upper_hit |=> !upper_region_select_n;
    endproperty
    a_upper_sel: assert property (p_upper_sel) else $error("upper select missing in its range");

    property p_lower_off;
        @(posedge clock) disable iff (!rstn) !lower_cfg.en_mem && !lower_cfg.en_io |=> lower_region_select_n;
    endproperty
    a_lower_off: assert property (p_lower_off) else $error("disabled lower select went active");

endmodule

// ### tb/lbc_far_model.sv
module lbc_far_model
    import lbc_pkg::*;
(
    input wire logic clock,
    input wire logic rstn,
    input wire lbc_ctl_s ctl,
    input wire logic ctl_oe,
    input wire logic [3:0] wait_cycles,
    input wire logic mute,
    output logic ready_pin,
    output logic lock_in
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [3:0] count;

    // ----------------
    // target answer
    // ----------------
    // ready after wait states; mute stalls the cycle
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            count <= 4'h0;
            ready_pin <= 1'b0;
        end
        else if (ctl_oe && (!ctl.read_n || !ctl.write_n))
        begin
            count <= (count == 4'hF) ? count : count + 4'h1;
            ready_pin <= !mute && (count >= wait_cycles);
        end
        else
        begin
            // not-ready is driven, never left at the last value
            count <= 4'h0;
            ready_pin <= 1'b0;
        end
    end

    // weak pull-up in reset or while floated
    assign lock_in = (!rstn || !ctl_oe) ? 1'b1 : ctl.lock_n;
endmodule

// ### tb/lbc_top_test.sv
module lbc_top_test
    import lbc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    typedef struct packed {lbc_req_s r; logic [9:0] e;} lbc_row_s;
    logic clock = 0;
    logic rstn = 0;
    logic req_valid = 0;
    lbc_req_s req = '0;
    logic cfg_we = 0;
    logic cfg_sel_lower = 0;
    lbc_region_s cfg_data = '0;
    logic hold = 0;
    logic coproc_error_n = 1;
    logic coproc_transfer_request = 0;
    logic mute = 0;
    logic [3:0] wait_cycles = 4'h2;
    logic ready_pin, lock_in, req_ready, done, ctl_oe, data_oe, bus_grant_ack, coproc_select_n;
    logic upper_region_select_n, lower_region_select_n, coproc_irq, coproc_xfer_pending, lock_in_seen;
    logic [7:0] coproc_irq_vector;
    lbc_ctl_s ctl;
    int errors = 0;
    int num_checks = 0;
    int n;
    logic [9:0] seen;
    logic [7:0] vec = '0;
    // flags: read, write, enable, direction, upper, lower, coproc, lock, enable outside strobe, irq
    lbc_row_s rows [6] = '{{20'hF_FC00, 5'h01, 10'h2A0}, {20'hF_FFFF, 5'h11, 10'h1E0},
        {20'hF_FBFF, 5'h01, 10'h280}, {20'hF_FC00, 5'h09, 10'h280}, {20'h0_0000, 5'h11, 10'h1C0},
        {20'h8_00F8, 5'h15, 10'h1C8}};

    always #12.5 clock = ~clock;

    lbc_top i_lbc_top (.clock(clock), .rstn(rstn), .req_valid(req_valid), .req(req), .req_ready(req_ready),
        .done(done), .cfg_we(cfg_we), .cfg_sel_lower(cfg_sel_lower), .cfg_data(cfg_data), .ready_pin(ready_pin),
        .hold(hold), .coproc_error_n(coproc_error_n), .coproc_transfer_request(coproc_transfer_request),
        .lock_in(lock_in), .ctl(ctl), .ctl_oe(ctl_oe), .data_oe(data_oe), .bus_grant_ack(bus_grant_ack),
        .coproc_select_n(coproc_select_n), .upper_region_select_n(upper_region_select_n),
        .lower_region_select_n(lower_region_select_n), .coproc_irq(coproc_irq),
        .coproc_irq_vector(coproc_irq_vector), .coproc_xfer_pending(coproc_xfer_pending),
        .lock_in_seen(lock_in_seen));

    lbc_far_model i_lbc_far_model (.clock(clock), .rstn(rstn), .ctl(ctl), .ctl_oe(ctl_oe),
        .wait_cycles(wait_cycles), .mute(mute), .ready_pin(ready_pin), .lock_in(lock_in));

    // ----------------
    // shared tasks
    // ----------------
    task automatic check(input logic [19:0] got, input logic [19:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic end_of_test();
        $display("%0d checks, %0d mismatches", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // one edge first, so req_valid is never set in the step that cleared it
    task automatic run_cycle(input lbc_req_s r);
        @(posedge clock);
        n = 0;
        seen = '0;
        req <= r;
        req_valid <= 1'b1;
        do
        begin
            @(posedge clock);
            n++;
            seen |= {!ctl.read_n, !ctl.write_n, !ctl.data_transceiver_enable_n, 1'b0, !upper_region_select_n,
                !lower_region_select_n, !coproc_select_n, !ctl.lock_n,
                !ctl.data_transceiver_enable_n && ctl.read_n && ctl.write_n, coproc_irq};
            if (!ctl.data_transceiver_enable_n)
                seen[6] = ctl.transceiver_direction;
            if (coproc_irq)
                vec = coproc_irq_vector;
        end while (done !== 1'b1 && n < 300);
        req_valid <= 1'b0;
    endtask

    task automatic wait_ack(input logic val);
        for (int i = 0; i < 30 && bus_grant_ack !== val; i++)
            @(posedge clock);
    endtask

    task automatic delayed_hold(input int cycles, input logic val);
        fork
            begin
                repeat (cycles) @(posedge clock);
                hold <= val;
            end
        join_none
    endtask

    // ----------------
    // main sequence
    // ----------------
    initial
    begin
        repeat (12) @(posedge clock);
        rstn <= 1'b1;
        check(20'({ctl.read_n, ctl.write_n, ctl.data_transceiver_enable_n, ctl_oe, bus_grant_ack,
            upper_region_select_n, lower_region_select_n, coproc_select_n}), 20'h0_00E7);
        $display("test reset done");
        for (int i = 0; i < 6; i++)
        begin
            run_cycle(rows[i].r);
            check(20'(seen), 20'(rows[i].e));
        end
        $display("test table done");
        // a stalled target keeps the cycle open
        mute <= 1'b1;
        wait_cycles <= 4'h6;
        fork
            begin
                repeat (40) @(posedge clock);
                mute <= 1'b0;
            end
        join_none
        run_cycle({20'hF_FC00, 5'h01});
        check(20'(n > 40), 20'h0_0001);
        cfg_sel_lower <= 1'b1;
        cfg_data <= '{lo: 20'h0_0000, hi: 20'h3_FFFF, en_mem: 1'b1, en_io: 1'b0, ignore_ready: 1'b1};
        cfg_we <= 1'b1;
        @(posedge clock);
        cfg_we <= 1'b0;
        mute <= 1'b1;
        run_cycle({20'h0_1000, 5'h01});
        check(20'(seen), 20'h0_0290);
        check(20'(n < 40), 20'h0_0001);
        mute <= 1'b0;
        $display("test ready and regions done");
        hold <= 1'b1;
        wait_ack(1'b1);
        check(20'({bus_grant_ack, ctl_oe, data_oe, req_ready}), 20'h0_0008);
        repeat (20) @(posedge clock);
        check(20'(bus_grant_ack), 20'h0_0001);
        delayed_hold(30, 1'b0);
        run_cycle({20'hF_FC00, 5'h01});
        check(20'(n > 30), 20'h0_0001);
        check(20'(bus_grant_ack), 20'h0_0000);
        $display("test hold done");
        delayed_hold(3, 1'b1);
        run_cycle({20'hF_FC00, 5'h02});
        check(20'(seen), 20'h0_02A4);
        check(20'(lock_in_seen), 20'h0_0001);
        repeat (20) @(posedge clock);
        check(20'(bus_grant_ack), 20'h0_0000);
        hold <= 1'b0;
        run_cycle({20'hF_FC00, 5'h03});
        hold <= 1'b1;
        wait_ack(1'b1);
        check(20'(bus_grant_ack), 20'h0_0001);
        hold <= 1'b0;
        wait_ack(1'b0);
        check(20'(bus_grant_ack), 20'h0_0000);
        $display("test lock done");
        coproc_error_n <= 1'b0;
        // the error pin needs two edges through the synchroniser before the request
        repeat (2) @(posedge clock);
        run_cycle({20'h8_00F8, 5'h05});
        check(20'(seen), 20'h0_0289);
        check(20'(vec), 20'h0_0010);
        coproc_error_n <= 1'b1;
        // other side raises then parks the request low
        coproc_transfer_request <= 1'b1;
        repeat (6) @(posedge clock);
        check(20'(coproc_xfer_pending), 20'h0_0001);
        coproc_transfer_request <= 1'b0;
        repeat (6) @(posedge clock);
        check(20'(coproc_xfer_pending), 20'h0_0000);
        $display("test coprocessor done");
        // a second reset must disable the programmed lower select again
        rstn <= 1'b0;
        repeat (2) @(posedge clock);
        check(20'({ctl_oe, bus_grant_ack, lower_region_select_n, upper_region_select_n}), 20'h0_0003);
        rstn <= 1'b1;
        repeat (2) @(posedge clock);
        run_cycle({20'h0_0000, 5'h01});
        check(20'(seen), 20'h0_0280);
        $display("test second reset done");
        end_of_test();
    end

    // whole run needs about 300 cycles
    initial
    begin
        repeat (20000) @(posedge clock);
        errors++;
        $display("unexpected at %0t: watchdog expired", $time);
        end_of_test();
    end
endmodule
